//--- core/spp_top.sv
// Serial programming port: pin sampling, command frames, address counter and memories.
`timescale 1ns/1ns
`include "spp_cfg.svh"
// How it works
// - Config word one bit 7 enables low-voltage entry pin.
// - Only high-voltage entry may clear that bit.
// - Six command bits, falling edge, LSB first.
// - Data frame: start, fourteen bits, stop.
// - Read drives pin rising edges two to sixteen.
// - Load captures bits from second falling edge.
// - Load-configuration sets address 0x2000, drops data.
// - Configuration space left only by leaving programming mode.
// - Program load fills the fourteen-bit write latch.
// - Data load keeps eight bits, zeros above.
// - 256 data bytes; protected reads give zero.
// - Data read gives byte in low bits.
// - Increment advances address, no data frame.
// - Begin-erase clears row or one data byte.
// - Row erase stops after 32 words, busy until end; protection bits kept.
// - Begin-program writes user or 2000h-2008h exactly.
// - End stops work, presets latch to ones.
// - Load, read and increment command codes.
// - Erase, program and end command codes.
// - Address 0x1FFF goes to 0x2000, wraps at 0x3FFF.
// - Entering programming mode clears the address.
module spp_top
  import spp_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // Programming pins, asynchronous to i_clk
  input  wire logic i_prog_clock_pin,
  input  wire logic i_prog_data_pin,
  input  wire logic i_reset_vpp_pin,
  input  wire logic i_vpp_high,
  input  wire logic i_lv_entry_pin,
  // Data pin drive
  output logic      o_prog_data_pin,
  output logic      o_prog_data_pin_oe,
  // Status
  output logic      o_prog_mode,
  output logic      o_lv_entry_input,
  output logic      o_prog_busy
);
  logic [4:0]  meta_q;       // First synchroniser stage.
  logic [4:0]  sync_q;       // Second synchroniser stage.
  logic        pclk_prev_q;  // Previous programming clock level.
  logic        rstp_prev_q;  // Previous reset pin level.
  logic        pclk_s, pdat_s, rstp_s, vpp_s, lve_s;
  logic        rise, fall;
  spp_mode_t   mode_q;       // Entry method, or off.
  logic        in_prog;
  logic        prog_q;       // Registered mode flag for the output.
  spp_fs_t     fs_q;         // Front end phase.
  logic [4:0]  cnt_q;        // Falling edges seen in this phase.
  logic [5:0]  cmd_q;        // Command shift register.
  logic [5:0]  cmd_nxt;
  logic [13:0] dsh_q;        // Data shift register.
  logic [4:0]  cur_q;        // Command owning the data frame.
  logic        push_v_q;     // Entry waiting for the buffer.
  spp_ent_t    push_q;
  spp_ent_t    ent;
  logic        pop;
  logic [13:0] addr_q;       // Address counter.
  logic [13:0] wlatch_q;     // Write data latch.
  logic        sel_dat_q;    // Last load or read targeted data memory.
  logic [13:0] cfg1_q;       // Configuration word one.
  logic        busy_q;       // Erase or write in progress.
  logic        er_run_q;     // Row erase sequencer running.
  logic        er_cfg_q;     // Row erase targets configuration memory.
  logic [4:0]  er_cnt_q;
  logic        rd_pend_q;    // Read data due next cycle.
  logic        rd_dat_q;     // Pending read is from data memory.
  logic [13:0] tx_q;         // Word sent by a read frame.
  logic        in_cfg, cp_off, cpd_off;
  logic        pm_we, cm_we, dm_we;
  logic [11:0] pm_a;
  logic [4:0]  cm_a;
  logic [13:0] pm_d, cm_d, pm_q, cm_q;
  logic [7:0]  dm_d, dm_q;

  spp_buf_if in_if ();
  spp_buf_if out_if ();

  // Two flip-flops on every pin before any logic looks at it.
  // They reset to the released pin levels, so a mid-session reset sees no false entry edge.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_q <= `SPP_PIN_IDLE;
      sync_q <= `SPP_PIN_IDLE;
    end else begin
      meta_q <= {i_lv_entry_pin, i_vpp_high, i_reset_vpp_pin, i_prog_data_pin,
                 i_prog_clock_pin};
      sync_q <= meta_q;
    end
  end
  assign {lve_s, vpp_s, rstp_s, pdat_s, pclk_s} = sync_q;

  // Edge detection on the synchronised clock and reset pins.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pclk_prev_q <= 1'b0;
      rstp_prev_q <= 1'b1;
    end else begin
      pclk_prev_q <= pclk_s;
      rstp_prev_q <= rstp_s;
    end
  end
  assign rise = pclk_s && !pclk_prev_q;
  assign fall = !pclk_s && pclk_prev_q;

  // Mode entry on the reset pin's rising edge; a low reset pin always ends the mode.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !rstp_s) begin
      mode_q <= MD_OFF;
    end else if (!rstp_prev_q && mode_q == MD_OFF) begin
      if (vpp_s) begin
        mode_q <= MD_HV;
      end else if (cfg1_q[`SPP_LVP_BIT] && lve_s) begin
        mode_q <= MD_LV;
      end
    end else if (mode_q == MD_LV && !lve_s) begin
      // Dropping the entry pin leaves low-voltage mode.
      mode_q <= MD_OFF;
    end
  end
  assign in_prog = mode_q != MD_OFF;

  // Status outputs, registered.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      prog_q <= 1'b0;
    end else begin
      prog_q <= in_prog;
    end
  end
  assign o_prog_mode = prog_q;
  assign o_lv_entry_input = cfg1_q[`SPP_LVP_BIT];
  assign o_prog_busy = busy_q;

  // The front end stalls while an entry waits, so no command is lost to a full buffer.
  assign cmd_nxt = {pdat_s, cmd_q[5:1]};
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !in_prog) begin
      fs_q     <= FS_CMD;
      cnt_q    <= 5'd0;
      cmd_q    <= 6'h00;
      dsh_q    <= 14'h0000;
      cur_q    <= CMD_LOAD_CFG;
      push_v_q <= 1'b0;
      push_q   <= '0;
    end else if (push_v_q) begin
      if (in_if.ready) begin
        push_v_q <= 1'b0;
      end
    end else if (fall) begin
      cnt_q <= cnt_q + 5'd1;
      unique case (fs_q)
        FS_CMD: begin
          cmd_q <= cmd_nxt;
          if (cnt_q == `SPP_CMD_LAST) begin
            cnt_q <= 5'd0;
            cur_q <= cmd_nxt[4:0];
            if (spp_has_data(cmd_nxt[4:0])) begin
              fs_q <= FS_DATA;
            end
            if (spp_known(cmd_nxt[4:0]) &&
                (!spp_has_data(cmd_nxt[4:0]) || spp_is_read(cmd_nxt[4:0]))) begin
              push_v_q <= 1'b1;
              push_q   <= '{cmd: cmd_nxt[4:0], word: 14'h0000};
            end
          end
        end
        FS_DATA: begin
          if (cnt_q != 5'd0 && cnt_q <= `SPP_DAT_LAST) begin
            dsh_q <= {pdat_s, dsh_q[13:1]};
          end
          if (cnt_q == `SPP_FRAME_LAST) begin
            fs_q  <= FS_CMD;
            cnt_q <= 5'd0;
            if (!spp_is_read(cur_q)) begin
              push_v_q <= 1'b1;
              push_q   <= '{cmd: cur_q, word: dsh_q};
            end
          end
        end
      endcase
    end
  end
  assign in_if.valid = push_v_q;
  assign in_if.data  = push_q;

  // Data pin drive for read frames, changed on rising edges.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !in_prog) begin
      o_prog_data_pin    <= 1'b0;
      o_prog_data_pin_oe <= 1'b0;
    end else if (rise && fs_q == FS_DATA && spp_is_read(cur_q)) begin
      // drive from second to sixteenth rise
      if (cnt_q == `SPP_RD_ON) begin
        o_prog_data_pin_oe <= 1'b1;
        o_prog_data_pin    <= tx_q[0];
      end else if (cnt_q == `SPP_FRAME_LAST) begin
        o_prog_data_pin_oe <= 1'b0;
        o_prog_data_pin    <= 1'b0;
      end else if (o_prog_data_pin_oe) begin
        o_prog_data_pin <= tx_q[cnt_q[3:0] - 4'd1];
      end
    end
  end

  spp_buf u_buf (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .up        (in_if),
    .dn        (out_if)
  );

  // The executor waits while erasing a row or fetching read data.
  assign out_if.ready = !er_run_q && !rd_pend_q;
  assign pop     = out_if.valid && out_if.ready;
  assign ent     = out_if.data;
  assign in_cfg  = addr_q[13] && addr_q[12:5] == 8'h00;
  assign cp_off  = cfg1_q[`SPP_CP_BIT];
  assign cpd_off = cfg1_q[`SPP_CPD_BIT];

  // Address counter.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !in_prog) begin
      addr_q <= 14'h0000;
    end else if (pop && ent.cmd == CMD_LOAD_CFG) begin
      addr_q <= `SPP_CFG_BASE;
    end else if (pop && ent.cmd == CMD_INC_ADDR) begin
      addr_q <= {addr_q[13] | (&addr_q[12:0]), addr_q[12:0] + 13'd1};
    end
  end

  // Write latch and target memory.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wlatch_q  <= `SPP_ONES;
      sel_dat_q <= 1'b0;
    end else if (pop) begin
      unique case (ent.cmd)
        CMD_LOAD_PROG: begin
          wlatch_q  <= ent.word;
          sel_dat_q <= 1'b0;
        end
        CMD_LOAD_DATA: begin
          wlatch_q  <= {6'h00, ent.word[7:0]};
          sel_dat_q <= 1'b1;
        end
        CMD_READ_PROG: sel_dat_q <= 1'b0;
        CMD_READ_DATA: sel_dat_q <= 1'b1;
        CMD_END_PROG: wlatch_q <= `SPP_ONES;
        default: ;
      endcase
    end
  end

  // Configuration word one; the entry bit stays set unless high voltage was used.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cfg1_q <= `SPP_CFG1_RST;
    end else if (pop && ent.cmd == CMD_BEGIN_PROG && !sel_dat_q &&
                 addr_q == `SPP_CFG1_ADDR) begin
      cfg1_q <= wlatch_q;
      if (mode_q != MD_HV) begin
        cfg1_q[`SPP_LVP_BIT] <= 1'b1;
      end
    end
  end

  // Externally timed erase and write: busy until the end command.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !in_prog) begin
      busy_q   <= 1'b0;
      er_run_q <= 1'b0;
      er_cfg_q <= 1'b0;
      er_cnt_q <= 5'd0;
    end else if (pop && ent.cmd == CMD_END_PROG) begin
      busy_q   <= 1'b0;
      er_run_q <= 1'b0;
    end else if (pop && (ent.cmd == CMD_BEGIN_ERASE || ent.cmd == CMD_BEGIN_PROG)) begin
      busy_q <= 1'b1;
      if (ent.cmd == CMD_BEGIN_ERASE && !sel_dat_q) begin
        er_run_q <= 1'b1;
        er_cfg_q <= in_cfg;
        er_cnt_q <= 5'd0;
      end
    end else if (er_run_q) begin
      er_cnt_q <= er_cnt_q + 5'd1;
      er_run_q <= er_cnt_q != `SPP_ROW_LAST;
    end
  end

  // Memory strobes for row erase, single-byte erase and word writes.
  always_comb begin
    pm_we = 1'b0;
    cm_we = 1'b0;
    dm_we = 1'b0;
    pm_a  = addr_q[11:0];
    cm_a  = addr_q[4:0];
    pm_d  = wlatch_q;
    cm_d  = wlatch_q;
    dm_d  = wlatch_q[7:0];
    if (er_run_q) begin
      pm_a  = {addr_q[11:5], er_cnt_q};
      cm_a  = er_cnt_q;
      pm_d  = `SPP_ONES;
      cm_d  = `SPP_ONES;
      pm_we = !er_cfg_q && cp_off;
      cm_we = er_cfg_q && er_cnt_q != `SPP_CFG1_IDX && er_cnt_q != `SPP_CFG2_IDX;
    end else if (pop && ent.cmd == CMD_BEGIN_ERASE && sel_dat_q) begin
      dm_we = cpd_off;
      dm_d  = `SPP_BYTE_ONES;
    end else if (pop && ent.cmd == CMD_BEGIN_PROG) begin
      // user space or exact configuration address
      if (sel_dat_q) begin
        dm_we = cpd_off;
      end else if (in_cfg) begin
        cm_we = addr_q <= `SPP_CFG_TOP && addr_q != `SPP_CFG1_ADDR;
      end else begin
        pm_we = cp_off;
      end
    end
  end

  spp_mem #(.AW(12), .DW(14)) u_pmem (
    .i_clk(i_clk), .i_we(pm_we), .i_addr(pm_a), .i_wdata(pm_d), .o_rdata(pm_q));
  spp_mem #(.AW(5), .DW(14)) u_cmem (
    .i_clk(i_clk), .i_we(cm_we), .i_addr(cm_a), .i_wdata(cm_d), .o_rdata(cm_q));
  spp_mem #(.AW(8), .DW(8)) u_dmem (
    .i_clk(i_clk), .i_we(dm_we), .i_addr(addr_q[7:0]), .i_wdata(dm_d), .o_rdata(dm_q));

  // Read fetch: memory read data is registered, so the word lands a cycle after the pop.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rd_pend_q <= 1'b0;
      rd_dat_q  <= 1'b0;
      tx_q      <= 14'h0000;
    end else if (pop && spp_is_read(ent.cmd)) begin
      rd_pend_q <= 1'b1;
      rd_dat_q  <= ent.cmd == CMD_READ_DATA;
    end else if (rd_pend_q) begin
      rd_pend_q <= 1'b0;
      if (rd_dat_q) begin
        tx_q <= cpd_off ? {6'h00, dm_q} : 14'h0000;
      end else if (addr_q == `SPP_CFG1_ADDR) begin
        tx_q <= cfg1_q;
      end else if (in_cfg) begin
        tx_q <= cm_q;
      end else begin
        tx_q <= cp_off ? pm_q : 14'h0000;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_rd_on;
    rise && fs_q == FS_DATA && spp_is_read(cur_q) && cnt_q == 5'd1 |=> o_prog_data_pin_oe;
  endproperty
  a_rd_on: assert property (p_rd_on) else $error("Pin not driven at rise two.");
  property p_rd_off;
    rise && fs_q == FS_DATA && cnt_q == 5'd15 |=> !o_prog_data_pin_oe;
  endproperty
  a_rd_off: assert property (p_rd_off) else $error("Pin held after rise 16.");
  property p_frame;
    fall && !push_v_q && fs_q == FS_DATA && cnt_q == 5'd15 |=> fs_q == FS_CMD && cnt_q == 5'd0;
  endproperty
  a_frame: assert property (p_frame) else $error("Frame not closed at 16.");
  property p_lcfg;
    pop && ent.cmd == CMD_LOAD_CFG |=> (addr_q == 14'h2000) [*2];
  endproperty
  a_lcfg: assert property (p_lcfg) else $error("Load config address wrong.");
  property p_stay;
    addr_q[13] && mode_q == MD_HV && rstp_s |=> addr_q[13];
  endproperty
  a_stay: assert property (p_stay) else $error("Left configuration space.");
  property p_wrap;
    pop && ent.cmd == CMD_INC_ADDR && addr_q == 14'h3fff |=> addr_q == 14'h2000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("Address did not wrap.");
  property p_clr;
    !in_prog |=> addr_q == 14'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("Address not cleared.");
  property p_ldat;
    pop && ent.cmd == CMD_LOAD_DATA |=> wlatch_q[13:8] == 6'h00 && sel_dat_q;
  endproperty
  a_ldat: assert property (p_ldat) else $error("Data load kept upper bits.");
  property p_end;
    pop && ent.cmd == CMD_END_PROG |=> !busy_q && !er_run_q && wlatch_q == 14'h3fff;
  endproperty
  a_end: assert property (p_end) else $error("End did not stop and preset.");
  property p_lvp;
    cfg1_q[7] && mode_q != MD_HV |=> cfg1_q[7];
  endproperty
  a_lvp: assert property (p_lvp) else $error("Entry bit cleared without HV.");
  property p_erase;
    pop && ent.cmd == CMD_BEGIN_ERASE && !sel_dat_q |=> er_run_q [*8] ##25 !er_run_q;
  endproperty
  a_erase: assert property (p_erase) else $error("Row erase length wrong.");

  c_read: cover property (rise && cnt_q == 5'd15 && o_prog_data_pin_oe);
  c_erase: cover property (er_run_q && er_cnt_q == 5'd31);
  c_lv: cover property (mode_q == MD_LV);
  c_wrap: cover property (pop && ent.cmd == CMD_INC_ADDR && addr_q == 14'h3fff);
endmodule

//--- common/spp_cfg.svh
// Addresses, field positions, reset values and frame counts of the serial programming port.
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH
// Start of configuration space, loaded by the load-configuration command.
`define SPP_CFG_BASE   14'h2000
// Last writable configuration location.
`define SPP_CFG_TOP    14'h2008
// Address of configuration word one.
`define SPP_CFG1_ADDR  14'h2007
// Configuration memory indexes of the two configuration words.
`define SPP_CFG1_IDX   5'd7
`define SPP_CFG2_IDX   5'd8
// Erased value of a program word and of a data byte.
`define SPP_ONES       14'h3fff
`define SPP_BYTE_ONES  8'hff
// Reset value of configuration word one (erased, low-voltage entry on).
`define SPP_CFG1_RST   14'h3fff
// Bit positions inside configuration word one.
`define SPP_LVP_BIT    7
`define SPP_CPD_BIT    8
`define SPP_CP_BIT     13
// Falling-edge index of the last command bit.
`define SPP_CMD_LAST   5'd5
// Cycle indexes inside a 16-cycle data frame.
`define SPP_RD_ON      5'd1
`define SPP_DAT_LAST   5'd14
`define SPP_FRAME_LAST 5'd15
// Last word index of a 32-word erase row.
`define SPP_ROW_LAST   5'd31
// Synchroniser reset pattern: reset pin released, every other pin low.
`define SPP_PIN_IDLE   5'h04
`endif

//--- common/spp_pkg.sv
// Types and decode helpers of the serial programming port.
package spp_pkg;
  typedef enum logic [4:0] {
    CMD_LOAD_CFG    = 5'b00000,
    CMD_LOAD_PROG   = 5'b00010,
    CMD_READ_PROG   = 5'b00100,
    CMD_INC_ADDR    = 5'b00110,
    CMD_LOAD_DATA   = 5'b00011,
    CMD_READ_DATA   = 5'b00101,
    CMD_BEGIN_ERASE = 5'b01000,
    CMD_BEGIN_PROG  = 5'b11000,
    CMD_BULK_PROG   = 5'b01001,
    CMD_BULK_DATA   = 5'b01011,
    CMD_CHIP_ERASE  = 5'b11111,
    CMD_END_PROG    = 5'b10111
  } spp_cmd_t;
  // How programming mode was entered.
  typedef enum logic [1:0] {MD_OFF = 2'b00, MD_HV = 2'b01, MD_LV = 2'b10} spp_mode_t;
  // Serial front end: command bits or data frame.
  typedef enum logic {FS_CMD = 1'b0, FS_DATA = 1'b1} spp_fs_t;
  // One decoded command with its data word.
  typedef struct packed {
    logic [4:0]  cmd;
    logic [13:0] word;
  } spp_ent_t;

  // True for commands followed by a 16-cycle data frame.
  function automatic logic spp_has_data(input logic [4:0] c);
    return c == CMD_LOAD_CFG || c == CMD_LOAD_PROG || c == CMD_READ_PROG ||
           c == CMD_LOAD_DATA || c == CMD_READ_DATA;
  endfunction

  // True for the two read commands.
  function automatic logic spp_is_read(input logic [4:0] c);
    return c == CMD_READ_PROG || c == CMD_READ_DATA;
  endfunction

  // True for any listed command code.
  function automatic logic spp_known(input logic [4:0] c);
    return spp_has_data(c) || c == CMD_INC_ADDR || c == CMD_BEGIN_ERASE ||
           c == CMD_BEGIN_PROG || c == CMD_BULK_PROG || c == CMD_BULK_DATA ||
           c == CMD_CHIP_ERASE || c == CMD_END_PROG;
  endfunction
endpackage

//--- common/spp_buf_if.sv
// Valid/ready carrier for decoded commands between the front end and the executor.
`timescale 1ns/1ns
interface spp_buf_if;
  logic               valid;  // Entry offered.
  logic               ready;  // Entry accepted.
  spp_pkg::spp_ent_t  data;   // Command and data word.
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface

//--- core/spp_mem.sv
// Single-port memory array with a registered read port.
`timescale 1ns/1ns
module spp_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          i_clk,
  // Access port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);
  // Storage cells; contents are not reset, like a real array.
  logic [DW-1:0] mem_q [2**AW];

  // Write on strobe, read the addressed word every cycle.
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_addr] <= i_wdata;
    end
    o_rdata <= mem_q[i_addr];
  end
endmodule

//--- core/spp_buf.sv
// Two-entry command buffer with valid/ready on both sides.
`timescale 1ns/1ns
module spp_buf (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // Filling and draining sides
  spp_buf_if.rx     up,
  spp_buf_if.tx     dn
);
  spp_pkg::spp_ent_t slot_q [2];  // Entry storage.
  logic              wr_q;        // Write pointer.
  logic              rd_q;        // Read pointer.
  logic [1:0]        cnt_q;       // Entries held.
  logic              push;
  logic              pop;

  // Full and empty come straight from the count.
  assign up.ready = cnt_q != 2'd2;
  assign dn.valid = cnt_q != 2'd0;
  assign dn.data  = slot_q[rd_q];
  assign push     = up.valid && up.ready;
  assign pop      = dn.valid && dn.ready;

  // Store an accepted entry.
  always_ff @(posedge i_clk) begin
    if (push) begin
      slot_q[wr_q] <= up.data;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) begin
        wr_q <= !wr_q;
      end
      if (pop) begin
        rd_q <= !rd_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'd1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'd1;
      end
    end
  end
endmodule

//--- bench/spp_prog_model.sv
// Programmer model that drives the serial programming pins of the port.
`timescale 1ns/1ns
module spp_prog_model (
  // Clock and device drive
  input  wire logic        i_clk,
  input  wire logic        i_dout,
  input  wire logic        i_oe,
  // Programming pins
  output logic             o_clk_pin,
  output logic             o_data_pin,
  output logic             o_rst_pin,
  output logic             o_vpp,
  output logic             o_lv_pin,
  // Captured read word
  output logic [13:0]      o_rd_word,
  output logic             o_rd_valid
);
  logic drv_q;  // Level the model puts on the data pin.
  // The device wins while it drives; a released pin toggles so stale bits never match.
  assign o_data_pin = i_oe ? i_dout : drv_q;
  // Clock, data and reset start low, as high-voltage entry expects clock and data low.
  // The voltage and entry pins are set by the entry task before reset first rises.
  initial begin
    {o_clk_pin, drv_q, o_rst_pin, o_rd_valid} = '0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // One 800 ns clock: high 5 cycles, sampled just before the fall, low 3 cycles.
  task automatic cyc(input logic d, input logic rel, output logic s);
    @(posedge i_clk);
    o_clk_pin <= 1'b1;
    drv_q     <= rel ? ~drv_q : d;
    wait_n(4);
    #10 s = o_data_pin;
    @(posedge i_clk);
    o_clk_pin <= 1'b0;
    wait_n(2);
  endtask
  // entry order: reset low, entry pin, then reset high.
  task automatic enter(input logic hv, input logic lv);
    o_rst_pin <= 1'b0;
    wait_n(4);
    o_vpp    <= hv;
    o_lv_pin <= lv;
    wait_n(4);
    o_rst_pin <= 1'b1;
    wait_n(8);
  endtask
  // six bits LSB first, then a gap over 1 us.
  task automatic cmd(input logic [5:0] c);
    logic s;
    for (int i = 0; i < 6; i++) cyc(c[i], 1'b0, s);
    wait_n(12);
  endtask
  // start bit, fourteen bits, stop bit, all 16 cycles.
  task automatic load(input logic [13:0] w);
    logic s;
    cyc(1'b0, 1'b0, s);
    for (int i = 0; i < 14; i++) cyc(w[i], 1'b0, s);
    cyc(1'b0, 1'b0, s);
    wait_n(12);
  endtask
  // Read frame: pin released all 16 cycles, bit k seen on rise k+2.
  task automatic read();
    logic        s;
    logic [15:0] f;
    for (int i = 0; i < 16; i++) begin
      cyc(1'b0, 1'b1, s);
      f[i] = s;
    end
    @(posedge i_clk);
    o_rd_word  <= f[14:1];
    o_rd_valid <= 1'b1;
    @(posedge i_clk);
    o_rd_valid <= 1'b0;
    wait_n(11);
  endtask
endmodule

//--- bench/serial_flash_programming_port_test.sv
// Self-checking bench: programmer model drives the port, a monitor checks read-backs.
`timescale 1ns/1ns
module serial_flash_programming_port_test;
  logic        i_clk, i_sys_rst;            // System clock and reset.
  logic        clk_p, dat_p, rst_p, vpp, lv; // Pins from the model.
  logic        dout, oe, mode, lvi, busy;    // Port outputs.
  logic [13:0] rd_word, ex_v, w, b, w2;      // Read word, expectation, data.
  logic        rd_valid;                     // Read word ready.
  logic [13:0] exp_q[$];                     // Expected read-backs, oldest first.
  int          fail_count, checks_done, cyc_n;
  spp_top dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_prog_clock_pin(clk_p),
    .i_prog_data_pin(dat_p), .i_reset_vpp_pin(rst_p), .i_vpp_high(vpp), .i_lv_entry_pin(lv),
    .o_prog_data_pin(dout), .o_prog_data_pin_oe(oe), .o_prog_mode(mode),
    .o_lv_entry_input(lvi), .o_prog_busy(busy));
  spp_prog_model prog_u (.i_clk(i_clk), .i_dout(dout), .i_oe(oe), .o_clk_pin(clk_p),
    .o_data_pin(dat_p), .o_rst_pin(rst_p), .o_vpp(vpp), .o_lv_pin(lv),
    .o_rd_word(rd_word), .o_rd_valid(rd_valid));
  // 10 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task automatic chk(input string n, input logic [13:0] s, input logic [13:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Issue a read, note what must come back, and see the pin released afterwards.
  task automatic rd(input logic [5:0] c, input logic [13:0] e);
    exp_q.push_back(e);
    prog_u.cmd(c);
    prog_u.read();
    chk("oe_after", {13'h0, oe}, 14'h0);
  endtask
  // Write one word through load, begin-program and end-program, checking busy.
  task automatic wr(input logic [5:0] c, input logic [13:0] d);
    prog_u.cmd(c);
    prog_u.load(d);
    prog_u.cmd({$urandom_range(1, 0) == 1, 5'b11000});
    chk("busy_on", {13'h0, busy}, 14'h1);
    prog_u.cmd(6'h17);
    chk("busy_off", {13'h0, busy}, 14'h0);
  endtask
  // load one before the first erase or program.
  task automatic prime();
    prog_u.cmd(6'h02);
    prog_u.load(14'h0001);
  endtask
  // load configuration with a dropped word, then step to configuration word one.
  task automatic to_cfg1();
    prog_u.cmd(6'h00);
    prog_u.load(w);
    repeat (7) prog_u.cmd(6'h06);
  endtask
  // Monitor: every read word is compared with the oldest note.
  always @(posedge i_clk) begin
    if (rd_valid === 1'b1) begin
      ex_v = (exp_q.size() > 0) ? exp_q.pop_front() : 14'hxxxx;
      chk("read_word", rd_word, ex_v);
    end
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge i_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    fail_count = 0;
    checks_done = 0;
    cyc_n = 0;
    i_sys_rst = 1'b1;
    w = $urandom(32'hec6c3770);
    w = $urandom() & 14'h3fff;
    b = $urandom() & 14'h3fff;
    w2 = $urandom() & 14'h3fff;
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    chk("lv_input", {13'h0, lvi}, 14'h1);
    prog_u.enter(1'b1, 1'b0);
    chk("hv_mode", {13'h0, mode}, 14'h1);
    prime();
    wr(6'h02, w);
    rd(6'h04, w);
    prog_u.cmd(6'h01);
    rd(6'h04, w);
    prog_u.cmd(6'h06);
    wr(6'h03, b);
    rd(6'h05, {6'h0, b[7:0]});
    prog_u.cmd(6'h08);
    prog_u.cmd(6'h17);
    rd(6'h05, 14'h00ff);
    prog_u.cmd(6'h00);
    prog_u.load(w);
    wr(6'h02, w2);
    prog_u.enter(1'b1, 1'b0);
    rd(6'h04, w);
    prog_u.cmd(6'h00);
    prog_u.load(b);
    rd(6'h04, w2);
    // A system reset in mid-session drops the mode and must not re-enter it.
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk("rst_mode", {13'h0, mode}, 14'h0);
    prog_u.enter(1'b0, 1'b1);
    chk("lv_mode", {13'h0, mode}, 14'h1);
    rd(6'h04, w);
    // Row erase of program memory, then configuration word one written in both modes.
    prime();
    prog_u.cmd(6'h08);
    prog_u.cmd(6'h17);
    rd(6'h04, 14'h3fff);
    to_cfg1();
    wr(6'h02, 14'h0000);
    rd(6'h04, 14'h0080);
    rd(6'h05, 14'h0000);
    prog_u.enter(1'b1, 1'b0);
    prime();
    to_cfg1();
    wr(6'h02, 14'h3f7f);
    rd(6'h04, 14'h3f7f);
    chk("lv_off", {13'h0, lvi}, 14'h0);
    prog_u.enter(1'b0, 1'b1);
    chk("lv_refused", {13'h0, mode}, 14'h0);
    chk("queue_empty", exp_q.size(), 14'h0);
    finish_test();
  end
endmodule
